// ---- inc/wid_pkg.sv ----
// Purpose: Shared constants and types for the wake and interrupt dispatcher.
// Assumes: One core clock, synchronous active-high reset.
// Notes:   Register map and the fixed port change vector live here; other vectors sit in the vector table.
package wid_pkg;

    localparam int unsigned N_SRC = 6;

    // Source indices.
    localparam int unsigned SRC_EXT  = 0;
    localparam int unsigned SRC_PORT = 1;
    localparam int unsigned SRC_TMR  = 2;
    localparam int unsigned SRC_CMP  = 3;
    localparam int unsigned SRC_TMR3 = 4;
    localparam int unsigned SRC_ADC  = 5;

    // Register offsets.
    localparam logic [3:0] OFS_IRQ_EN   = 4'h0;
    localparam logic [3:0] OFS_WAKE_EN  = 4'h1;
    localparam logic [3:0] OFS_PENDING  = 4'h2;
    localparam logic [3:0] OFS_STATUS   = 4'h3;
    localparam logic [3:0] OFS_VEC_BASE = 4'h4;

    // Status register field positions.
    localparam int unsigned ST_GIE   = 0;
    localparam int unsigned ST_MODE  = 1;
    localparam int unsigned ST_ASLP  = 3;
    localparam int unsigned ST_WDCLR = 4;

    // Reset values.
    localparam logic [5:0] IRQ_EN_RST  = 6'h00;
    localparam logic [5:0] WAKE_EN_RST = 6'h00;
    localparam logic [5:0] PEND_RST    = 6'h00;

    // Port change vector; other vectors are registers of their own.
    localparam logic [11:0] VEC_PORT = 12'h006;

    // Sources that may wake the core through a wake enable.
    localparam logic [5:0] WAKE_CAPABLE = 6'h2b;

    typedef enum logic [1:0] {
        WID_NORMAL,
        WID_GREEN,
        WID_IDLE,
        WID_SLEEP
    } wid_mode_t;

    typedef enum logic [1:0] {
        WID_RUN,
        WID_ASLEEP
    } wid_state_t;

    typedef struct packed {
        logic        valid;
        logic        branch;
        logic [2:0]  src;
        logic [11:0] vector;
    } wid_dispatch_t;

endpackage : wid_pkg

// ---- src/wid_vec_mem.sv ----
// Purpose: Small table of interrupt vector addresses, one per source.
// Assumes: Synchronous write, registered read.
// Notes:   Port change entry is fixed and cannot be rewritten.
`timescale 1ns/1ps
module wid_vec_mem #(
    parameter int unsigned DEPTH = 6,
    parameter int unsigned WIDTH = 12
) (
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire logic                     wr_en,
    input  wire logic [2:0]               wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [2:0]               rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] rd_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= WIDTH'(i);
            end
            rd_reg <= '0;
        end else begin
            if (wr_en && wr_addr != 3'(wid_pkg::SRC_PORT) && wr_addr < 3'(DEPTH)) begin
                mem_reg[wr_addr] <= wr_data;
            end
            // The port change vector is fixed regardless of the table contents.
            if (rd_addr == 3'(wid_pkg::SRC_PORT)) begin
                rd_reg <= WIDTH'(wid_pkg::VEC_PORT);
            end else if (rd_addr < 3'(DEPTH)) begin
                rd_reg <= mem_reg[rd_addr];
            end else begin
                rd_reg <= '0;
            end
        end
    end

    assign rd_data = rd_reg;

endmodule : wid_vec_mem

// ---- src/wid_dispatch.sv ----
// Purpose: Decides wake-up and vector branch for six event sources.
// Assumes: Event inputs are one-cycle pulses on the core clock.
// Notes:   Dispatch is one source at a time, lowest index first.
//
// Notes on behaviour
// - In sleep and idle, pin, port, comparator and conversion sources wake only with their wake enable set, timers never wake from sleep and wake from idle only with their interrupt enable set.
// - After a wake the core resumes at the next instruction when global interrupts are off or the waking source's interrupt enable is clear.
// - With global interrupts on and the source interrupt enable set, a wake branches to the source vector, wake-capable sources needing their wake enable too.
// - In green and normal, wake enables are ignored and an enabled source branches when global interrupts are on, else continues, while a disabled one does nothing.
// - The sleep instruction enters sleep, or idle when idle_sel is set, and clears the watchdog without stopping it.
// - Wakes from these sources continue execution and never reset the device.
// - The port change interrupt branches to vector address 006h.
`timescale 1ns/1ps
module wid_dispatch #(
    parameter int unsigned VEC_W = 12
) (
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic [5:0]                src_event,
    input  wire logic                      sleep_instr,
    input  wire logic                      global_irq_on_instr,
    input  wire logic                      global_irq_off_instr,
    input  wire logic                      idle_sel,
    input  wire logic [1:0]                run_mode,
    input  wire logic                      dispatch_ack,
    input  wire logic [3:0]                reg_addr,
    input  wire logic [15:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [15:0]               reg_rdata,
    output wid_pkg::wid_dispatch_t         dispatch,
    output logic                           core_wake,
    output logic                           core_asleep,
    output logic                           watchdog_clear,
    output logic                           core_reset_req
);

    ////////////////////////////////////////////////////////////////////////////
    logic [5:0]          irq_en_reg, irq_en_next;
    logic [5:0]          wake_en_reg, wake_en_next;
    logic [5:0]          pend_reg, pend_next;
    logic                gie_reg, gie_next;
    wid_pkg::wid_mode_t  mode_reg, mode_next;
    wid_pkg::wid_state_t state_reg, state_next;
    logic                wdclr_reg, wdclr_next;
    logic                wake_reg, wake_next;
    logic [15:0]         rdata_reg, rdata_next;
    wid_pkg::wid_dispatch_t disp_reg, disp_next;
    logic                busy_reg, busy_next;
    logic [2:0]          src_reg, src_next;
    logic                br_reg, br_next;
    logic                asleep_reg, asleep_next;

    logic [5:0]          qualify;
    logic [5:0]          branchable;
    logic                any_q;
    logic [2:0]          pick;
    logic [VEC_W-1:0]    vec_rd;
    logic                vec_wr;

    assign vec_wr    = reg_wr && (reg_addr >= wid_pkg::OFS_VEC_BASE)
                       && (reg_addr < wid_pkg::OFS_VEC_BASE + 4'(wid_pkg::N_SRC));

    wid_vec_mem #(
        .DEPTH (wid_pkg::N_SRC),
        .WIDTH (VEC_W)
    ) u_vec (
        .clk     (clk),
        .reset   (reset),
        .wr_en   (vec_wr),
        .wr_addr (3'(reg_addr - wid_pkg::OFS_VEC_BASE)),
        .wr_data (reg_wdata[VEC_W-1:0]),
        .rd_addr (pick),
        .rd_data (vec_rd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Per-source qualification by mode and enables.
    generate
        for (genvar i = 0; i < 6; i++) begin : g_q
            always_comb begin
                if (mode_reg == wid_pkg::WID_SLEEP) begin
                    qualify[i] = wid_pkg::WAKE_CAPABLE[i] && wake_en_reg[i];
                end else if (mode_reg == wid_pkg::WID_IDLE) begin
                    qualify[i] = wid_pkg::WAKE_CAPABLE[i] ? wake_en_reg[i]
                                                          : irq_en_reg[i];
                end else begin
                    qualify[i] = irq_en_reg[i];
                end
                branchable[i] = gie_reg && irq_en_reg[i];
            end
        end
    endgenerate

    always_comb begin
        pick = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (pend_reg[i] && qualify[i]) begin
                pick = 3'(i);
            end
        end
    end
    assign any_q = |(pend_reg & qualify);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        irq_en_next  = irq_en_reg;
        wake_en_next = wake_en_reg;
        pend_next    = pend_reg;
        gie_next     = gie_reg;
        mode_next    = mode_reg;
        state_next   = state_reg;
        wdclr_next   = 1'b0;
        wake_next    = 1'b0;
        rdata_next   = 16'h0000;
        disp_next    = '0;
        busy_next    = busy_reg;
        src_next     = src_reg;
        br_next      = br_reg;

        if (global_irq_on_instr) begin
            gie_next = 1'b1;
        end else if (global_irq_off_instr) begin
            gie_next = 1'b0;
        end

        if (reg_wr && reg_addr == wid_pkg::OFS_IRQ_EN) begin
            irq_en_next = reg_wdata[5:0];
        end else if (reg_wr && reg_addr == wid_pkg::OFS_WAKE_EN) begin
            wake_en_next = reg_wdata[5:0];
        end else if (reg_wr && reg_addr == wid_pkg::OFS_PENDING) begin
            pend_next = pend_reg & ~reg_wdata[5:0];
        end

        // A new event wins over a software clear in the same cycle.
        pend_next = pend_next | src_event;

        if (reg_rd) begin
            if (reg_addr == wid_pkg::OFS_IRQ_EN) begin
                rdata_next = {10'h000, irq_en_reg};
            end else if (reg_addr == wid_pkg::OFS_WAKE_EN) begin
                rdata_next = {10'h000, wake_en_reg};
            end else if (reg_addr == wid_pkg::OFS_PENDING) begin
                rdata_next = {10'h000, pend_reg};
            end else if (reg_addr == wid_pkg::OFS_STATUS) begin
                rdata_next = {11'h000, wdclr_reg, asleep_reg, mode_reg, gie_reg};
            end else begin
                rdata_next = 16'h0000;
            end
        end

        case (state_reg)
            wid_pkg::WID_RUN: begin
                if (sleep_instr) begin
                    state_next = wid_pkg::WID_ASLEEP;
                    mode_next  = idle_sel ? wid_pkg::WID_IDLE : wid_pkg::WID_SLEEP;
                    wdclr_next = 1'b1;
                end else begin
                    mode_next = wid_pkg::wid_mode_t'({1'b0, run_mode[0]});
                end
            end
            wid_pkg::WID_ASLEEP: begin
                if (any_q && !busy_reg) begin
                    // Wake resumes the program; no reset is requested.
                    wake_next  = 1'b1;
                    state_next = wid_pkg::WID_RUN;
                    mode_next  = wid_pkg::wid_mode_t'({1'b0, run_mode[0]});
                end
            end
            default: state_next = wid_pkg::WID_RUN;
        endcase
        asleep_next = (state_next == wid_pkg::WID_ASLEEP);

        // Registered vector read needs one cycle, so the choice is held first.
        if (!busy_reg && any_q && (state_reg == wid_pkg::WID_RUN || !sleep_instr)) begin
            busy_next = 1'b1;
            src_next  = pick;
            br_next   = branchable[pick];
        end else if (busy_reg && !disp_reg.valid) begin
            disp_next.valid  = 1'b1;
            disp_next.branch = br_reg;
            disp_next.src    = src_reg;
            disp_next.vector = br_reg ? 12'(vec_rd) : 12'h000;
        end else if (busy_reg && disp_reg.valid) begin
            disp_next = disp_reg;
            if (dispatch_ack) begin
                disp_next = '0;
                busy_next = 1'b0;
                pend_next[src_reg] = src_event[src_reg];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_en_reg  <= wid_pkg::IRQ_EN_RST;
            wake_en_reg <= wid_pkg::WAKE_EN_RST;
            pend_reg    <= wid_pkg::PEND_RST;
            gie_reg     <= 1'b0;
            mode_reg    <= wid_pkg::WID_NORMAL;
            state_reg   <= wid_pkg::WID_RUN;
            wdclr_reg   <= 1'b0;
            wake_reg    <= 1'b0;
            rdata_reg   <= 16'h0000;
            disp_reg    <= '0;
            busy_reg    <= 1'b0;
            src_reg     <= 3'h0;
            br_reg      <= 1'b0;
            asleep_reg  <= 1'b0;
        end else begin
            irq_en_reg  <= irq_en_next;
            wake_en_reg <= wake_en_next;
            pend_reg    <= pend_next;
            gie_reg     <= gie_next;
            mode_reg    <= mode_next;
            state_reg   <= state_next;
            wdclr_reg   <= wdclr_next;
            wake_reg    <= wake_next;
            rdata_reg   <= rdata_next;
            disp_reg    <= disp_next;
            busy_reg    <= busy_next;
            src_reg     <= src_next;
            br_reg      <= br_next;
            asleep_reg  <= asleep_next;
        end
    end

    assign reg_rdata      = rdata_reg;
    assign dispatch       = disp_reg;
    assign core_wake      = wake_reg;
    assign core_asleep    = asleep_reg;
    assign watchdog_clear = wdclr_reg;
    assign core_reset_req = 1'b0 & wake_reg;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_sleep_entry;
        sleep_instr && state_reg == wid_pkg::WID_RUN;
    endsequence

    sequence s_pick;
        !busy_reg && any_q && (state_reg == wid_pkg::WID_RUN || !sleep_instr);
    endsequence

    timer_no_sleep_wake_a: assert property (@(posedge clk) disable iff (reset)
        (mode_reg == wid_pkg::WID_SLEEP && core_asleep && (pend_reg & wid_pkg::WAKE_CAPABLE
         & wake_en_reg) == 6'h00) |=> !core_wake)
        else $error("Sleep woke without a wake-enabled source.");

    sleep_entry_clear_a: assert property (@(posedge clk) disable iff (reset)
        s_sleep_entry |=> (watchdog_clear && core_asleep))
        else $error("Sleep entry did not clear the watchdog.");

    no_branch_gie_a: assert property (@(posedge clk) disable iff (reset)
        (s_pick ##0 !(gie_reg && irq_en_reg[pick])) |-> ##2 (dispatch.valid && !dispatch.branch))
        else $error("Branch taken without enables.");

    port_vector_a: assert property (@(posedge clk) disable iff (reset)
        (dispatch.valid && dispatch.branch && dispatch.src == 3'(wid_pkg::SRC_PORT))
        |-> dispatch.vector == wid_pkg::VEC_PORT)
        else $error("Port change vector is wrong.");

    pending_hold_a: assert property (@(posedge clk) disable iff (reset)
        (|src_event) |=> ((pend_reg & $past(src_event)) == $past(src_event)))
        else $error("Pending flag lost an event.");

    never_reset_a: assert property (@(posedge clk) disable iff (reset)
        core_wake |-> !core_reset_req)
        else $error("Wake requested a reset.");

    enabled_dispatch_a: assert property (@(posedge clk) disable iff (reset)
        (!busy_reg && any_q && state_reg == wid_pkg::WID_RUN && !sleep_instr
         && gie_reg && irq_en_reg[pick]) |-> ##2 (dispatch.valid && dispatch.branch))
        else $error("Enabled source did not branch.");

    wake_branch_a: assert property (@(posedge clk) disable iff (reset)
        core_wake |=> (dispatch.valid
                       && dispatch.branch == (gie_reg && irq_en_reg[dispatch.src])))
        else $error("Wake dispatch order broken.");

endmodule : wid_dispatch

// ---- tb/wid_core_model.sv ----
// Purpose: Stand-in for the processor core that accepts dispatches and counts wakes.
// Assumes: A dispatch is held until the acknowledge pulse is seen.
// Notes:   The acknowledge delay is an input so one run can act prompt and slow.
`timescale 1ns/1ps
module wid_core_model (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic [3:0]             ack_delay,
    input  wire wid_pkg::wid_dispatch_t dispatch,
    input  wire logic                   core_wake,
    output logic                        dispatch_ack,
    output wid_pkg::wid_dispatch_t      last,
    output int                          n_seen,
    output int                          n_wake
);
    logic [3:0] wait_reg;

    // The guard on our own acknowledge keeps one dispatch from being counted twice.
    always_ff @(posedge clk) begin
        if (reset) begin
            wait_reg     <= 4'h0;
            dispatch_ack <= 1'b0;
            last         <= '0;
            n_seen       <= 0;
            n_wake       <= 0;
        end else begin
            dispatch_ack <= 1'b0;
            if (core_wake) begin
                n_wake <= n_wake + 1;
            end
            if (dispatch.valid && !dispatch_ack) begin
                if (wait_reg == ack_delay) begin
                    dispatch_ack <= 1'b1;
                    last         <= dispatch;
                    n_seen       <= n_seen + 1;
                    wait_reg     <= 4'h0;
                end else begin
                    wait_reg <= wait_reg + 4'h1;
                end
            end
        end
    end
endmodule : wid_core_model

// ---- tb/wake_interrupt_dispatch_tb_top.sv ----
// Purpose: Self-checking bench for the wake and interrupt dispatcher.
// Assumes: The core model acknowledges every dispatch.
// Notes:   Each sleep case starts from a fresh reset so a core left asleep cannot leak.
`timescale 1ns/1ps
module wake_interrupt_dispatch_tb_top;
    logic                   clk, reset, sleep_instr, idle_sel, reg_wr, reg_rd;
    logic                   global_irq_on_instr, global_irq_off_instr, dispatch_ack;
    logic                   core_wake, core_asleep, watchdog_clear, core_reset_req;
    logic [5:0]             src_event;
    logic [1:0]             run_mode;
    logic [3:0]             reg_addr, ack_delay;
    logic [15:0]            reg_wdata, reg_rdata, rd;
    wid_pkg::wid_dispatch_t dispatch, last;
    int                     n_seen, n_wake, n_errors, num_checks;

    wid_dispatch i_wid_dispatch (.clk(clk), .reset(reset), .src_event(src_event),
        .sleep_instr(sleep_instr), .global_irq_on_instr(global_irq_on_instr),
        .global_irq_off_instr(global_irq_off_instr), .idle_sel(idle_sel),
        .run_mode(run_mode), .dispatch_ack(dispatch_ack), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dispatch(dispatch), .core_wake(core_wake), .core_asleep(core_asleep),
        .watchdog_clear(watchdog_clear), .core_reset_req(core_reset_req));
    wid_core_model i_wid_core_model (.clk(clk), .reset(reset), .ack_delay(ack_delay),
        .dispatch(dispatch), .core_wake(core_wake), .dispatch_ack(dispatch_ack),
        .last(last), .n_seen(n_seen), .n_wake(n_wake));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask : reg_read

    task automatic do_reset(input int n);
        @(posedge clk);
        reset <= 1'b1;
        repeat (n) @(posedge clk);
        reset <= 1'b0;
    endtask : do_reset

    task automatic setup(input logic [5:0] irq, input logic [5:0] wk, input logic gie);
        reg_write(wid_pkg::OFS_IRQ_EN, {10'h000, irq});
        reg_write(wid_pkg::OFS_WAKE_EN, {10'h000, wk});
        @(posedge clk);
        global_irq_on_instr  <= gie;
        global_irq_off_instr <= !gie;
        @(posedge clk);
        global_irq_on_instr  <= 1'b0;
        global_irq_off_instr <= 1'b0;
    endtask : setup

    task automatic go_sleep(input logic idle);
        @(posedge clk);
        idle_sel    <= idle;
        sleep_instr <= 1'b1;
        @(posedge clk);
        sleep_instr <= 1'b0;
        #1;
        check("watchdog_clear", {15'h0, watchdog_clear}, 16'h0001);
        check("asleep", {15'h0, core_asleep}, 16'h0001);
        reg_read(wid_pkg::OFS_STATUS);
        check("sleep status", {13'h0, rd[3:1]}, {13'h0, 2'h3, !idle});
    endtask : go_sleep

    // Pulses one source, then judges wake, dispatch and the pending flag it leaves.
    task automatic fire(input int s, input logic slp, input logic ew, input logic ed,
                        input logic eb);
        int w0, d0;
        w0 = n_wake;
        d0 = n_seen;
        @(posedge clk);
        src_event <= 6'h01 << s;
        @(posedge clk);
        src_event <= 6'h00;
        repeat (24) @(posedge clk);
        #1;
        check("wake count", 16'(n_wake - w0), {15'h0, ew});
        check("asleep after", {15'h0, core_asleep}, {15'h0, slp & !ew});
        check("dispatch count", 16'(n_seen - d0), {15'h0, ed});
        check("reset request", {15'h0, core_reset_req}, 16'h0000);
        if (ed) begin
            check("source", {13'h0, last.src}, 16'(s));
            check("branch", {15'h0, last.branch}, {15'h0, eb});
            if (s == 1 && eb) check("vector", {4'h0, last.vector}, 16'h0006);
        end
        reg_read(wid_pkg::OFS_PENDING);
        check("pending", {15'h0, rd[s]}, {15'h0, !ed});
        reg_write(wid_pkg::OFS_PENDING, 16'h0001 << s);
    endtask : fire

    ////////////////////////////////////////////////////////////////////////////////
    task automatic regs_test;
        reg_read(wid_pkg::OFS_IRQ_EN);
        check("irq_en reset", rd, {10'h000, wid_pkg::IRQ_EN_RST});
        reg_read(wid_pkg::OFS_WAKE_EN);
        check("wake_en reset", rd, {10'h000, wid_pkg::WAKE_EN_RST});
        reg_read(wid_pkg::OFS_PENDING);
        check("pending reset", rd, {10'h000, wid_pkg::PEND_RST});
        reg_read(wid_pkg::OFS_STATUS);
        check("status reset", rd, 16'h0000);
        reg_write(wid_pkg::OFS_IRQ_EN, 16'h003f);
        reg_read(wid_pkg::OFS_IRQ_EN);
        check("irq_en back", rd, 16'h003f);
        reg_read(4'hf);
        check("unmapped", rd, 16'h0000);
    endtask : regs_test

    // The port entry must refuse the write while the pin entry takes it.
    task automatic vec_test;
        reg_write(wid_pkg::OFS_VEC_BASE, 16'h0123);
        reg_write(wid_pkg::OFS_VEC_BASE + 4'h1, 16'h0abc);
        setup(6'h03, 6'h00, 1'b1);
        fire(0, 1'b0, 1'b0, 1'b1, 1'b1);
        check("pin vector", {4'h0, last.vector}, 16'h0123);
        fire(1, 1'b0, 1'b0, 1'b1, 1'b1);
    endtask : vec_test

    // Wake enables are all set here to show they change nothing while running.
    task automatic run_test;
        logic [5:0] m;
        for (int md = 0; md < 2; md++) begin
            for (int g = 0; g < 2; g++) begin
                for (int k = 0; k < 2; k++) begin
                    m = k ? 6'h2a : 6'h15;
                    run_mode <= 2'(md);
                    setup(m, 6'h3f, g[0]);
                    for (int s = 0; s < 6; s++) fire(s, 1'b0, 1'b0, m[s], g[0]);
                end
            end
        end
    endtask : run_test

    task automatic sleep_test;
        logic [5:0] irq, wk;
        logic       w;
        ack_delay <= 4'h4;
        run_mode  <= 2'h0;
        for (int i = 0; i < 2; i++) begin
            for (int g = 0; g < 2; g++) begin
                for (int c = 0; c < 3; c++) begin
                    irq = (c == 0) ? 6'h15 : (c == 1) ? 6'h2a : 6'h3f;
                    wk  = (c == 2) ? 6'h00 : 6'h3f;
                    for (int s = 0; s < 6; s++) begin
                        do_reset(2);
                        setup(irq, wk, g[0]);
                        go_sleep(i[0]);
                        w = wid_pkg::WAKE_CAPABLE[s] ? wk[s] : (i[0] & irq[s]);
                        fire(s, 1'b1, w, w, g[0] & irq[s]);
                    end
                end
            end
        end
    endtask : sleep_test

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        src_event = 6'h00;
        sleep_instr = 1'b0;
        idle_sel = 1'b0;
        global_irq_on_instr = 1'b0;
        global_irq_off_instr = 1'b0;
        run_mode = 2'h0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ack_delay = 4'h0;
        n_errors = 0;
        num_checks = 0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        regs_test;
        vec_test;
        run_test;
        sleep_test;
        conclude;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        conclude;
    end
endmodule : wake_interrupt_dispatch_tb_top
